/* File: inc/mif_pkg.sv */
// Constants and carrier types of the interrupt enable and flag logic
//
// Function
// - A core interrupt control register holds the enables and flags of the timer-zero, port-change and edge-pin sources and is readable and writable.
// - The core interrupt control register answers at index 0x0b, 0x8b, 0x10b and 0x18b, all four reaching one physical register.
// - Every flag is set by its source event whatever its own enable and the global enable hold.
// - Bit 7 of the core control register is the global enable, and while it is clear no request reaches the core.
// - A peripheral request is forwarded only when bit 6, the peripheral group enable, and its own enable are both set.
// - A peripheral enable register at index 0x8c holds one enable bit per group-one peripheral source; the capture/compare two enable is at 0x8d.
// - Bit 6 of the peripheral enable register gates the converter-done request, one enabling it.
// - Bit 3 of the peripheral enable register gates the serial port request, one enabling it.
// - Bit 2 of the peripheral enable register gates the capture/compare one request, one enabling it.
// - Bit 1 of the peripheral enable register gates the timer-two period match request, one enabling it.
// - Unimplemented bits of the peripheral enable register ignore writes and read as zero.
// - Reset clears every implemented enable and flag, the port-change flag included.
// - A second peripheral flag register at index 0x0d holds the capture/compare two flag.
`default_nettype none

package mif_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CORE_B0  = 10'h00b;
    localparam logic [9:0] IDX_CORE_B1  = 10'h08b;
    localparam logic [9:0] IDX_CORE_B2  = 10'h10b;
    localparam logic [9:0] IDX_CORE_B3  = 10'h18b;
    localparam logic [9:0] IDX_PFLAGS1  = 10'h00c;
    localparam logic [9:0] IDX_PFLAGS2  = 10'h00d;
    localparam logic [9:0] IDX_PEN1     = 10'h08c;
    localparam logic [9:0] IDX_PEN2     = 10'h08d;

    localparam int ADDR_W = 12;

    // Peripheral bit positions (enables and flags alike); capture/compare two is in group two
    localparam int BIT_ADC     = 6;
    localparam int BIT_SSP     = 3;
    localparam int BIT_CCP_ONE = 2;
    localparam int BIT_TMR_TWO = 1;
    localparam int BIT_TMR_ONE = 0;
    localparam int BIT_CCP_TWO = 0;

    localparam logic [7:0] PGRP1_MASK = 8'h4f;
    localparam logic [7:0] PGRP2_MASK = 8'h01;
    localparam logic [7:0] CORE_RESET = 8'h00;
    localparam logic [7:0] REG_RESET  = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_CORE   = 3'b001,
        SEL_PFLAG1 = 3'b010,
        SEL_PFLAG2 = 3'b011,
        SEL_PEN1   = 3'b100,
        SEL_PEN2   = 3'b101
    } mif_sel_t;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic timer_zero_overflow_enable;
        logic edge_pin_irq_enable;
        logic port_change_irq_enable;
        logic timer_zero_overflow_flag;
        logic edge_pin_irq_flag;
        logic port_change_irq_flag;
    } mif_core_t;

    // One-cycle event strobes from the interrupt sources
    typedef struct packed {
        logic timer_zero_overflow;
        logic external_edge_pin;
        logic port_change;
        logic adc_done;
        logic sync_serial;
        logic capcomp_one;
        logic timer_two_match;
        logic timer_one_overflow;
        logic capcomp_two;
    } mif_events_t;

endpackage

`default_nettype wire

/* File: hdl/mif_irq_logic.sv */
// Interrupt enable and flag logic with an AXI4-Lite register slave
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none

module mif_irq_logic (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // Interrupt sources and core
    input  wire mif_pkg::mif_events_t     events,
    input  wire logic                     irq_taken,
    input  wire logic                     return_from_interrupt,
    output logic                          irq,
    // AXI4-Lite write address
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);

    // Byte address to register select; four core mirrors share one select
    function automatic mif_pkg::mif_sel_t decode(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'h0) begin
            decode = mif_pkg::SEL_NONE;
        end else begin
            case (idx)
                mif_pkg::IDX_CORE_B0,
                mif_pkg::IDX_CORE_B1,
                mif_pkg::IDX_CORE_B2,
                mif_pkg::IDX_CORE_B3: decode = mif_pkg::SEL_CORE;
                mif_pkg::IDX_PFLAGS1: decode = mif_pkg::SEL_PFLAG1;
                mif_pkg::IDX_PFLAGS2: decode = mif_pkg::SEL_PFLAG2;
                mif_pkg::IDX_PEN1:    decode = mif_pkg::SEL_PEN1;
                mif_pkg::IDX_PEN2:    decode = mif_pkg::SEL_PEN2;
                default:              decode = mif_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // Register state
    mif_pkg::mif_core_t core_reg;
    mif_pkg::mif_core_t core_next;
    logic [7:0]         pflags1_reg;
    logic [7:0]         pflags1_next;
    logic [7:0]         pflags2_reg;
    logic [7:0]         pflags2_next;
    logic [7:0]         pen1_reg;
    logic [7:0]         pen1_next;
    logic [7:0]         pen2_reg;
    logic [7:0]         pen2_next;
    logic               irq_reg;
    logic               irq_next;

    // Bus state
    logic               aw_have_reg;
    logic [11:0]        aw_addr_reg;
    logic               w_have_reg;
    logic [7:0]         w_data_reg;
    logic               w_lane_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;

    // Write channel handshakes and the combined write
    wire                aw_hs      = s_axi_awvalid & s_axi_awready;
    wire                w_hs       = s_axi_wvalid & s_axi_wready;
    wire                aw_ok      = aw_have_reg | aw_hs;
    wire                w_ok       = w_have_reg | w_hs;
    wire                do_write   = aw_ok & w_ok;
    wire [11:0]         wr_addr    = aw_have_reg ? aw_addr_reg
                                                 : s_axi_awaddr;
    wire [7:0]          wr_byte    = w_have_reg ? w_data_reg
                                                : s_axi_wdata[7:0];
    wire                wr_lane    = w_have_reg ? w_lane_reg
                                                : s_axi_wstrb[0];
    wire mif_pkg::mif_sel_t wr_sel = decode(wr_addr);
    wire                wr_en      = do_write & wr_lane;

    wire                we_core    = wr_en & (wr_sel == mif_pkg::SEL_CORE);
    wire                we_pflag1  = wr_en & (wr_sel == mif_pkg::SEL_PFLAG1);
    wire                we_pflag2  = wr_en & (wr_sel == mif_pkg::SEL_PFLAG2);
    wire                we_pen1    = wr_en & (wr_sel == mif_pkg::SEL_PEN1);
    wire                we_pen2    = wr_en & (wr_sel == mif_pkg::SEL_PEN2);

    // Read channel
    wire                ar_hs      = s_axi_arvalid & s_axi_arready;
    wire mif_pkg::mif_sel_t rd_sel = decode(s_axi_araddr);
    wire [7:0]          rd_byte    =
        (rd_sel == mif_pkg::SEL_CORE)   ? core_reg    :
        (rd_sel == mif_pkg::SEL_PFLAG1) ? pflags1_reg :
        (rd_sel == mif_pkg::SEL_PFLAG2) ? pflags2_reg :
        (rd_sel == mif_pkg::SEL_PEN1)   ? pen1_reg    :
        (rd_sel == mif_pkg::SEL_PEN2)   ? pen2_reg    : 8'h00;

    // Source event vectors in register bit order
    wire [7:0] ev_grp1 = {1'b0,
                          events.adc_done,
                          2'b00,
                          events.sync_serial,
                          events.capcomp_one,
                          events.timer_two_match,
                          events.timer_one_overflow};
    wire [7:0] ev_grp2 = {7'h00, events.capcomp_two};

    // Core register: software value first, then hardware sets on top
    wire mif_pkg::mif_core_t core_sw = we_core ? mif_pkg::mif_core_t'(wr_byte)
                                               : core_reg;
    wire gie_next = return_from_interrupt ? 1'b1 :
                    irq_taken             ? 1'b0 :
                    core_sw.global_irq_enable;

    always_comb begin
        core_next = core_sw;
        core_next.global_irq_enable = gie_next;
        // Set wins over clear, enable state ignored
        core_next.timer_zero_overflow_flag =
            core_sw.timer_zero_overflow_flag
            | events.timer_zero_overflow;
        core_next.edge_pin_irq_flag =
            core_sw.edge_pin_irq_flag
            | events.external_edge_pin;
        core_next.port_change_irq_flag =
            core_sw.port_change_irq_flag
            | events.port_change;
    end

    // Peripheral flags and enables
    assign pflags1_next = ((we_pflag1 ? wr_byte : pflags1_reg) | ev_grp1)
                          & mif_pkg::PGRP1_MASK;
    assign pflags2_next = ((we_pflag2 ? wr_byte : pflags2_reg) | ev_grp2)
                          & mif_pkg::PGRP2_MASK;
    assign pen1_next    = (we_pen1 ? wr_byte : pen1_reg)
                          & mif_pkg::PGRP1_MASK;
    assign pen2_next    = (we_pen2 ? wr_byte : pen2_reg)
                          & mif_pkg::PGRP2_MASK;

    // Request combination
    wire core_pend =
        (core_reg.timer_zero_overflow_enable
            & core_reg.timer_zero_overflow_flag)
        | (core_reg.edge_pin_irq_enable & core_reg.edge_pin_irq_flag)
        | (core_reg.port_change_irq_enable
            & core_reg.port_change_irq_flag);
    wire adc_pend = pen1_reg[mif_pkg::BIT_ADC]
                    & pflags1_reg[mif_pkg::BIT_ADC];
    wire ssp_pend = pen1_reg[mif_pkg::BIT_SSP]
                    & pflags1_reg[mif_pkg::BIT_SSP];
    wire cc1_pend = pen1_reg[mif_pkg::BIT_CCP_ONE]
                    & pflags1_reg[mif_pkg::BIT_CCP_ONE];
    wire tm2_pend = pen1_reg[mif_pkg::BIT_TMR_TWO]
                    & pflags1_reg[mif_pkg::BIT_TMR_TWO];
    wire tm1_pend = pen1_reg[mif_pkg::BIT_TMR_ONE]
                    & pflags1_reg[mif_pkg::BIT_TMR_ONE];
    wire cc2_pend = pen2_reg[mif_pkg::BIT_CCP_TWO]
                    & pflags2_reg[mif_pkg::BIT_CCP_TWO];
    wire per_pend = core_reg.peripheral_group_enable
                    & (adc_pend | ssp_pend | cc1_pend
                       | tm2_pend | tm1_pend | cc2_pend);

    assign irq_next = core_reg.global_irq_enable
                      & (core_pend | per_pend);

    // Register file
    always_ff @(posedge clock) begin
        if (rst) begin
            core_reg    <= mif_pkg::CORE_RESET;
            pflags1_reg <= mif_pkg::REG_RESET;
            pflags2_reg <= mif_pkg::REG_RESET;
            pen1_reg    <= mif_pkg::REG_RESET;
            pen2_reg    <= mif_pkg::REG_RESET;
            irq_reg     <= 1'b0;
        end else begin
            core_reg    <= core_next;
            pflags1_reg <= pflags1_next;
            pflags2_reg <= pflags2_next;
            pen1_reg    <= pen1_next;
            pen2_reg    <= pen2_next;
            irq_reg     <= irq_next;
        end
    end

    // Write address and data holding
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_have_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
        end else begin
            aw_have_reg <= aw_ok & ~do_write;
            w_have_reg  <= w_ok & ~do_write;
            if (aw_hs) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
        end
    end

    // Write response and read data
    always_ff @(posedge clock) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= mif_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= mif_pkg::RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_sel == mif_pkg::SEL_NONE)
                              ? mif_pkg::RESP_SLVERR : mif_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (ar_hs) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {24'h000000, rd_byte};
                rresp_reg  <= (rd_sel == mif_pkg::SEL_NONE)
                              ? mif_pkg::RESP_SLVERR : mif_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // One write and one read at a time
    assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

endmodule

`default_nettype wire

/* File: test/mif_irq_logic_sva.sv */
// Concurrent checks on the ports of the interrupt flag logic
`default_nettype none

module mif_irq_logic_sva (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Core side
    input wire logic        irq_taken,
    input wire logic        return_from_interrupt,
    input wire logic        irq,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence core_ack;
        irq_taken && !return_from_interrupt;
    endsequence

    chk_rst_idle: assert property (disable iff (1'b0)
        rst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    chk_wr_answer: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    chk_wr_close: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");
    chk_wr_refuse: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_rd_close: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
    chk_rd_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_err_zero: assert property (s_axi_rvalid
        && s_axi_rresp == mif_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    chk_ack_drop: assert property (core_ack |=> ##1 !irq)
        else $error("request stayed after global disable");
endmodule

bind mif_irq_logic mif_irq_logic_sva u_sva (
    .clock(clock), .rst(rst), .irq_taken(irq_taken),
    .return_from_interrupt(return_from_interrupt), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

`default_nettype wire

/* File: test/mif_core_model.sv */
// Behavioural core that acknowledges and returns from interrupts
`default_nettype none

module mif_core_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Bench control
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    input  wire logic [7:0] svc_len,
    // Interrupt handshake
    input  wire logic       irq,
    output var logic        irq_taken,
    output var logic        return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt;
    logic busy;

    // Acts on the level request after a chosen delay
    always @(posedge clock) begin
        irq_taken <= 1'b0;
        return_from_interrupt <= 1'b0;
        if (rst) begin
            busy <= 1'b0;
            cnt <= 0;
        end else if (!busy && irq && ack_en) begin
            cnt <= (cnt >= ack_delay) ? 0 : cnt + 1;
            busy <= (cnt >= ack_delay);
            irq_taken <= (cnt >= ack_delay);
        end else if (busy) begin
            cnt <= (cnt >= svc_len) ? 0 : cnt + 1;
            busy <= (cnt < svc_len);
            return_from_interrupt <= (cnt >= svc_len);
        end
    end
endmodule

`default_nettype wire

/* File: test/mif_irq_logic_tb_top.sv */
// Self-checking bench for the interrupt enable and flag logic
`default_nettype none

module mif_irq_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_PF1  = {mif_pkg::IDX_PFLAGS1, 2'b00};
    localparam logic [11:0] A_PF2  = {mif_pkg::IDX_PFLAGS2, 2'b00};
    localparam logic [11:0] A_PEN1 = {mif_pkg::IDX_PEN1, 2'b00};
    localparam logic [11:0] A_PEN2 = {mif_pkg::IDX_PEN2, 2'b00};
    localparam logic [1:0]  OK     = mif_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR    = mif_pkg::RESP_SLVERR;
    logic [11:0] core_a [4];
    int          pbit [5] = '{6, 3, 2, 1, 0};
    int          pev [5]  = '{5, 4, 3, 2, 1};
    logic        clock = 1'b0, rst = 1'b1, irq, irq_taken, ret_int;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_delay = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    mif_pkg::mif_events_t events = '0;
    int          seed, error_cnt = 0, checks_done = 0, i, j, k, n;
    logic [7:0]  v;

    always #2 clock = ~clock;

    mif_irq_logic DUT (
        .clock(clock), .rst(rst), .events(events), .irq_taken(irq_taken),
        .return_from_interrupt(ret_int), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    mif_core_model u_core (
        .clock(clock), .rst(rst), .ack_en(ack_en), .ack_delay(ack_delay),
        .svc_len(8'h14), .irq(irq), .irq_taken(irq_taken),
        .return_from_interrupt(ret_int));

    function automatic logic exp_irq(logic [7:0] c, pe, pf);
        return c[7] && ((|(c[5:3] & c[2:0]))
            || (c[6] && |(pe & pf & mif_pkg::PGRP1_MASK)));
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {r[31:8], d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int t = 0; t < 50 && !s_axi_bvalid; t++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] ex,
                      input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int t = 0; t < 50 && !s_axi_rvalid; t++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
        check("rdata", s_axi_rdata, {24'h0, ex});
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic ev(input int b);
        @(posedge clock);
        events <= mif_pkg::mif_events_t'(9'h1 << b);
        @(posedge clock);
        events <= '0;
    endtask

    task automatic irq_is(input logic ex);
        repeat (2) @(posedge clock);
        check("irq", {31'h0, irq}, {31'h0, ex});
    endtask

    initial begin
        #80000;
        error_cnt++;
        test_done();
    end

    initial begin
        seed = 55;
        core_a = '{12'h02c, 12'h22c, 12'h42c, 12'h62c};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) rd(core_a[i], 8'h00, OK);
        rd(A_PEN1, 8'h00, OK);
        rd(A_PF2, 8'h00, OK);
        repeat (8) begin
            v = 8'($random(seed));
            j = {$random(seed)} % 4;
            wr(core_a[j], v, OK);
            rd(core_a[(j + 1) % 4], v, OK);
            irq_is(exp_irq(v, 8'h00, 8'h00));
        end
        v = 8'($random(seed));
        wr(A_PEN1, v, OK);
        rd(A_PEN1, v & mif_pkg::PGRP1_MASK, OK);
        wr(A_PF2, v, OK);
        rd(A_PF2, v & mif_pkg::PGRP2_MASK, OK);
        wr(12'h004, v, ERR);
        rd(12'h004, 8'h00, ERR);
        for (k = 0; k < 5; k++) begin
            v = 8'h1 << pbit[k];
            wr(core_a[k % 4], 8'h80, OK);
            wr(A_PF1, 8'h00, OK);
            wr(A_PEN1, v, OK);
            ev(pev[k]);
            rd(A_PF1, v, OK);
            irq_is(1'b0);
            wr(core_a[0], 8'hc0, OK);
            irq_is(exp_irq(8'hc0, v, v));
            wr(A_PEN1, 8'h00, OK);
            irq_is(1'b0);
        end
        for (k = 0; k < 3; k++) begin
            wr(core_a[0], 8'h20 >> k, OK);
            ev(8 - k);
            rd(core_a[3], (8'h20 >> k) | (8'h04 >> k), OK);
            irq_is(1'b0);
            wr(core_a[1], 8'h80 | (8'h24 >> k), OK);
            irq_is(1'b1);
        end
        ack_delay <= 4'($random(seed));
        ack_en <= 1'b1;
        for (n = 0; n < 40 && !irq_taken; n++) @(posedge clock);
        check("irq_taken", {31'h0, irq_taken}, 32'h1);
        ack_en <= 1'b0;
        irq_is(1'b0);
        rd(core_a[2], 8'h09, OK);
        for (n = 0; n < 40 && !ret_int; n++) @(posedge clock);
        check("ret_int", {31'h0, ret_int}, 32'h1);
        irq_is(1'b1);
        // Event strobe lands on the same edge as the clearing write
        fork
            wr(A_PF2, 8'h00, OK);
            begin
                @(posedge clock);
                events <= 9'h001;
                @(posedge clock);
                events <= '0;
            end
        join
        rd(A_PF2, 8'h01, OK);
        wr(core_a[0], 8'hc0, OK);
        wr(A_PEN2, 8'hff, OK);
        rd(A_PEN2, 8'h01, OK);
        irq_is(1'b1);
        s_axi_wstrb <= 4'he;
        wr(A_PEN2, 8'h00, OK);
        s_axi_wstrb <= 4'hf;
        irq_is(1'b1);
        wr(A_PEN2, 8'h00, OK);
        irq_is(1'b0);
        test_done();
    end
endmodule

`default_nettype wire
